// ### rtl/sie_consts.vh
`ifndef SIE_CONSTS_VH
`define SIE_CONSTS_VH
// register word addresses (byte address = 4 x index)
`define SIE_ADDR_W          8
`define SIE_OFF_ESET0       8'h00
`define SIE_OFF_ESET1       8'h04
`define SIE_OFF_ESET2       8'h08
`define SIE_OFF_ESET3       8'h0c
`define SIE_OFF_ECLR0       8'h10
`define SIE_OFF_ECLR1       8'h14
`define SIE_OFF_ECLR2       8'h18
`define SIE_OFF_ECLR3       8'h1c
`define SIE_OFF_PSET3       8'h20
`define SIE_OFF_PCLR3       8'h24
`define SIE_OFF_IRQ_STAT    8'h28
`define SIE_OFF_IRQ_MASK    8'h2c
// interrupt counts and field layout
`define SIE_NUM_IRQ         101
`define SIE_TOP_BITS        5
`define SIE_GRP_W           32
// block events: bit 0 = pending rose on enabled source, bit 1 = unmapped access
`define SIE_EV_W            2
`define SIE_EV_PEND         0
`define SIE_EV_BADADDR      1
// reset values
`define SIE_ENABLE_RST      101'h0
`define SIE_PEND_RST        101'h0
`define SIE_MASK_RST        2'h0
`endif

// ### rtl/sie_irq_enable.v
// Summary of operation
// - upper clear register reads raw pending 96-100
// - write one clears pending of n+96
// - writing zero changes nothing, except a plain write to the event mask register and an unmapped write, which raises an event
// - enable-set write one sets enable bit
// - enable-set/clear reads return enable state
// - enable-clear write one clears enable bit
// - disabled sources never reach gated outputs
// - set group0 bit n enables source n
// - set groups 1,2 map to n+32, n+64
// - set group3 bits 4-0 map 96-100
// - clear groups 0,1 map n, n+32
// - one private bit per source per register
// - upper clear reserved bits read zero
// - clear group2 maps n+64, clears enable
// - upper raw-set write one sets pending
`include "sie_consts.vh"
module sie_irq_enable #(
  parameter NUM_IRQ = `SIE_NUM_IRQ
) (
  input  wire                   mclk,
  input  wire                   sys_rst,
  input  wire [`SIE_ADDR_W-1:0] reg_addr,
  input  wire [31:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [31:0]            reg_rdata,
  input  wire [NUM_IRQ-1:0]     sys_irq_in,
  output reg  [NUM_IRQ-1:0]     pend_raw_out,
  output reg  [NUM_IRQ-1:0]     enable_out,
  output reg  [NUM_IRQ-1:0]     gated_pending_flag,
  output reg                    irq_out
);

  // enable mask for a group: full word except the 5-bit top group
  function [31:0] grp_mask;
    input [1:0] grp;
    begin
      grp_mask = (grp == 2'h3) ? 32'h0000001f : 32'hffffffff;
    end
  endfunction

  // place a group word onto the full interrupt vector
  function [NUM_IRQ-1:0] grp_spread;
    input [1:0]  grp;
    input [31:0] word;
    reg   [127:0] wide;
    begin
      wide = 128'h0;
      wide = {96'h0, word & grp_mask(grp)} << {grp, 5'h00};
      grp_spread = wide[NUM_IRQ-1:0];
    end
  endfunction

  // pick a group word off the full vector, reserved bits zero
  function [31:0] grp_pick;
    input [1:0]         grp;
    input [NUM_IRQ-1:0] vec;
    reg   [127:0] wide;
    begin
      wide = 128'h0;
      wide[NUM_IRQ-1:0] = vec;
      wide = wide >> {grp, 5'h00};
      grp_pick = wide[31:0] & grp_mask(grp);
    end
  endfunction

  // enable and pending state
  reg  [NUM_IRQ-1:0]       enable_r;
  reg  [NUM_IRQ-1:0]       enable_nxt;
  reg  [NUM_IRQ-1:0]       pend_r;
  reg  [NUM_IRQ-1:0]       pend_nxt;

  // source synchroniser and edge history
  reg  [NUM_IRQ-1:0]       irq_s1_r;
  reg  [NUM_IRQ-1:0]       irq_s2_r;
  reg  [NUM_IRQ-1:0]       irq_s3_r;
  wire [NUM_IRQ-1:0]       irq_rise;

  // block event status and mask
  reg  [`SIE_EV_W-1:0]     ev_stat_r;
  reg  [`SIE_EV_W-1:0]     ev_stat_nxt;
  reg  [`SIE_EV_W-1:0]     ev_mask_r;
  reg  [`SIE_EV_W-1:0]     ev_now;

  // register bus decode results
  reg  [NUM_IRQ-1:0]       en_set;
  reg  [NUM_IRQ-1:0]       en_clr;
  reg  [NUM_IRQ-1:0]       pd_set;
  reg  [NUM_IRQ-1:0]       pd_clr;
  reg  [`SIE_EV_W-1:0]     stat_clr;
  reg                      mask_wr;
  reg  [31:0]              rd_nxt;
  reg                      hit;

  // source edges, read only after the two-stage synchroniser
  assign irq_rise = irq_s2_r & ~irq_s3_r;

  // register hit check, unmapped accesses raise an event
  always @* begin
    hit = 1'b1;
    if (reg_wr || reg_rd) begin
      case (reg_addr)
        `SIE_OFF_ESET0: hit = 1'b1;
        `SIE_OFF_ESET1: hit = 1'b1;
        `SIE_OFF_ESET2: hit = 1'b1;
        `SIE_OFF_ESET3: hit = 1'b1;
        `SIE_OFF_ECLR0: hit = 1'b1;
        `SIE_OFF_ECLR1: hit = 1'b1;
        `SIE_OFF_ECLR2: hit = 1'b1;
        `SIE_OFF_ECLR3: hit = 1'b1;
        `SIE_OFF_PSET3: hit = 1'b1;
        `SIE_OFF_PCLR3: hit = 1'b1;
        `SIE_OFF_IRQ_STAT: hit = 1'b1;
        `SIE_OFF_IRQ_MASK: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // write decode into per-source set and clear vectors
  always @* begin
    en_set   = {NUM_IRQ{1'b0}};
    en_clr   = {NUM_IRQ{1'b0}};
    pd_set   = {NUM_IRQ{1'b0}};
    pd_clr   = {NUM_IRQ{1'b0}};
    stat_clr = {`SIE_EV_W{1'b0}};
    mask_wr  = 1'b0;
    if (reg_wr) begin
      // only one bits act, except the plain mask write; zeros leave state alone
      case (reg_addr)
        `SIE_OFF_ESET0: begin
          en_set = grp_spread(2'h0, reg_wdata);
        end
        `SIE_OFF_ESET1: begin
          en_set = grp_spread(2'h1, reg_wdata);
        end
        `SIE_OFF_ESET2: begin
          en_set = grp_spread(2'h2, reg_wdata);
        end
        `SIE_OFF_ESET3: begin
          en_set = grp_spread(2'h3, reg_wdata);
        end
        `SIE_OFF_ECLR0: begin
          en_clr = grp_spread(2'h0, reg_wdata);
        end
        `SIE_OFF_ECLR1: begin
          en_clr = grp_spread(2'h1, reg_wdata);
        end
        `SIE_OFF_ECLR2: begin
          en_clr = grp_spread(2'h2, reg_wdata);
        end
        `SIE_OFF_ECLR3: begin
          en_clr = grp_spread(2'h3, reg_wdata);
        end
        `SIE_OFF_PSET3: begin
          pd_set = grp_spread(2'h3, reg_wdata);
        end
        `SIE_OFF_PCLR3: begin
          pd_clr = grp_spread(2'h3, reg_wdata);
        end
        `SIE_OFF_IRQ_STAT: begin
          stat_clr = reg_wdata[`SIE_EV_W-1:0];
        end
        `SIE_OFF_IRQ_MASK: begin
          mask_wr = 1'b1;
        end
        default: begin
          en_set = {NUM_IRQ{1'b0}};
        end
      endcase
    end
  end

  // next enable state, clear wins over set on a collision
  always @* begin
    enable_nxt = (enable_r | en_set) & ~en_clr;
  end

  // next pending state, hardware edge beats a software clear
  always @* begin
    pend_nxt = (pend_r & ~pd_clr) | irq_rise | pd_set;
  end

  // block event register: set beats write-one-to-clear
  always @* begin
    ev_now                  = {`SIE_EV_W{1'b0}};
    ev_now[`SIE_EV_PEND]    = |((irq_rise | pd_set) & enable_r);
    ev_now[`SIE_EV_BADADDR] = ~hit;
    ev_stat_nxt = ev_stat_r;
    if (|stat_clr) begin
      ev_stat_nxt = ev_stat_r & ~stat_clr;
    end
    ev_stat_nxt = ev_stat_nxt | ev_now;
  end

  // read mux, answer lands one cycle after the strobe
  always @* begin
    rd_nxt = 32'h0;
    case (reg_addr)
      `SIE_OFF_ESET0: begin
        rd_nxt = grp_pick(2'h0, enable_r);
      end
      `SIE_OFF_ESET1: begin
        rd_nxt = grp_pick(2'h1, enable_r);
      end
      `SIE_OFF_ESET2: begin
        rd_nxt = grp_pick(2'h2, enable_r);
      end
      `SIE_OFF_ESET3: begin
        rd_nxt = grp_pick(2'h3, enable_r);
      end
      `SIE_OFF_ECLR0: begin
        rd_nxt = grp_pick(2'h0, enable_r);
      end
      `SIE_OFF_ECLR1: begin
        rd_nxt = grp_pick(2'h1, enable_r);
      end
      `SIE_OFF_ECLR2: begin
        rd_nxt = grp_pick(2'h2, enable_r);
      end
      `SIE_OFF_ECLR3: begin
        rd_nxt = grp_pick(2'h3, enable_r);
      end
      `SIE_OFF_PSET3: begin
        rd_nxt = grp_pick(2'h3, pend_r);
      end
      `SIE_OFF_PCLR3: begin
        rd_nxt = grp_pick(2'h3, pend_r);
      end
      `SIE_OFF_IRQ_STAT: begin
        rd_nxt = {30'h0, ev_stat_r};
      end
      `SIE_OFF_IRQ_MASK: begin
        rd_nxt = {30'h0, ev_mask_r};
      end
      default: begin
        rd_nxt = 32'h0;
      end
    endcase
    if (!reg_rd) begin
      rd_nxt = 32'h0;
    end
  end

  // two-stage synchroniser plus edge history for the sources
  always @(posedge mclk) begin
    if (sys_rst) begin
      irq_s1_r <= {NUM_IRQ{1'b0}};
      irq_s2_r <= {NUM_IRQ{1'b0}};
      irq_s3_r <= {NUM_IRQ{1'b0}};
    end else begin
      irq_s1_r <= sys_irq_in;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
    end
  end

  // enable state
  always @(posedge mclk) begin
    if (sys_rst) begin
      enable_r <= `SIE_ENABLE_RST;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // pending state, sticky until cleared
  always @(posedge mclk) begin
    if (sys_rst) begin
      pend_r <= `SIE_PEND_RST;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // block event status
  always @(posedge mclk) begin
    if (sys_rst) begin
      ev_stat_r <= {`SIE_EV_W{1'b0}};
    end else begin
      ev_stat_r <= ev_stat_nxt;
    end
  end

  // block event mask, plain read/write
  always @(posedge mclk) begin
    if (sys_rst) begin
      ev_mask_r <= `SIE_MASK_RST;
    end else begin
      if (mask_wr) begin
        ev_mask_r <= reg_wdata[`SIE_EV_W-1:0];
      end
    end
  end

  // read data, zero outside the answer cycle
  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= rd_nxt;
    end
  end

  // raw pending view for the mapping stage
  always @(posedge mclk) begin
    if (sys_rst) begin
      pend_raw_out <= {NUM_IRQ{1'b0}};
    end else begin
      pend_raw_out <= pend_nxt;
    end
  end

  // enable view for the mapping stage
  always @(posedge mclk) begin
    if (sys_rst) begin
      enable_out <= {NUM_IRQ{1'b0}};
    end else begin
      enable_out <= enable_nxt;
    end
  end

  // downstream mapping sees only enabled pending sources
  always @(posedge mclk) begin
    if (sys_rst) begin
      gated_pending_flag <= {NUM_IRQ{1'b0}};
    end else begin
      gated_pending_flag <= pend_nxt & enable_nxt;
    end
  end

  // level interrupt, high while an unmasked event is set
  always @(posedge mclk) begin
    if (sys_rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(ev_stat_nxt & ev_mask_r);
    end
  end

endmodule

// ### tb/sie_irq_enable_properties.sv
module sie_chk #(parameter NUM_IRQ = 101) (
  input wire logic               mclk, sys_rst, reg_wr, reg_rd, irq_out,
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata, reg_rdata,
  input wire logic [NUM_IRQ-1:0] sys_irq_in, pend_raw_out, enable_out, gated_pending_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // enable set, clear and readback, upper pending readback and gating
  a_set_grp0: assert property (reg_wr && reg_addr == 8'h00 |=>
    (enable_out[31:0] & $past(reg_wdata)) == $past(reg_wdata)) else $error("set0");
  a_set_grp1: assert property (reg_wr && reg_addr == 8'h04 |=>
    (enable_out[63:32] & $past(reg_wdata)) == $past(reg_wdata)) else $error("set1");
  a_set_grp3: assert property (reg_wr && reg_addr == 8'h0c |=>
    (enable_out[100:96] & $past(reg_wdata[4:0])) == $past(reg_wdata[4:0])) else $error("set3");
  a_clr_grp2: assert property (reg_wr && reg_addr == 8'h18 |=>
    (enable_out[95:64] & $past(reg_wdata)) == 0) else $error("clr2");
  a_zero_keep: assert property (reg_wr && reg_addr < 8'h20 && reg_wdata == 0 |=>
    $stable(enable_out)) else $error("zero");
  a_rd_enable: assert property (reg_rd && reg_addr == 8'h10 |=>
    reg_rdata == $past(enable_out[31:0])) else $error("rden");
  a_rd_upper: assert property (reg_rd && reg_addr == 8'h24 |=>
    reg_rdata == {27'h0, $past(pend_raw_out[100:96])}) else $error("rdup");
  a_gate_off: assert property (
    gated_pending_flag == (pend_raw_out & enable_out)) else $error("gate");
  // main scenarios
  c_irq: cover property ($rose(irq_out));
  c_gate: cover property (|gated_pending_flag);
  c_rdup: cover property (reg_rd && reg_addr == 8'h24);
endmodule
bind sie_irq_enable sie_chk #(.NUM_IRQ(NUM_IRQ)) u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .irq_out(irq_out), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sys_irq_in(sys_irq_in),
  .pend_raw_out(pend_raw_out), .enable_out(enable_out), .gated_pending_flag(gated_pending_flag));

// ### tb/sie_src_model.sv
module sie_src_model (
  input  wire logic         mclk,
  input  wire logic [100:0] lvl,
  output logic      [100:0] src
);
  timeunit 1ns;
  timeprecision 1ps;
  // sources hold a level, changing just after an edge
  initial src = '0;
  always @(posedge mclk) src <= lvl;
endmodule

// ### tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         mclk, sys_rst, reg_wr, reg_rd;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, p, m;
  logic [100:0] lvl;
  wire  [100:0] src, pend, en, gated;
  wire  [31:0]  reg_rdata;
  wire          irq_out;
  int           n_fail, check_count;
  sie_src_model u_src (.mclk(mclk), .lvl(lvl), .src(src));
  sie_irq_enable dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_irq_in(src),
    .pend_raw_out(pend), .enable_out(en), .gated_pending_flag(gated), .irq_out(irq_out));
  // clock
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read, data stands the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask
  task automatic stop_test;
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    n_fail++;
    stop_test;
  end
  // main sequence
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, lvl} = {3'b100, 141'h0};
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h24, 32'h0);
    for (int g = 0; g < 4; g++) begin
      p = 32'ha5c3_0f96 ^ g;
      m = (g == 3) ? 32'h1f : 32'hffff_ffff;
      wr(8'(4 * g), p);
      rd(8'(4 * g), p & m);
      wr(8'(16 + 4 * g), 32'h0);
      rd(8'(16 + 4 * g), p & m);
      wr(8'(16 + 4 * g), 32'h0000_ffff);
      rd(8'(4 * g), p & m & 32'hffff_0000);
    end
    chk("en0", en[31:0], 32'ha5c3_0000);
    chk("en1", en[63:32], 32'ha5c3_0000);
    chk("en3", en[100:96], 5'h00);
    wr(8'h20, 32'hffff_ff15);
    rd(8'h24, 32'h15);
    wr(8'h24, 32'h4);
    rd(8'h20, 32'h11);
    wr(8'h0c, 32'h1);
    repeat (2) @(posedge mclk);
    #1 chk("gated", gated[100:96], 5'h01);
    wr(8'h28, 32'h3);
    wr(8'h2c, 32'h1);
    wr(8'h24, 32'h1f);
    wr(8'h20, 32'h1);
    repeat (3) @(posedge mclk);
    #1 chk("irq", irq_out, 1'b1);
    wr(8'h28, 32'h1);
    repeat (2) @(posedge mclk);
    #1 chk("irq", irq_out, 1'b0);
    rd(8'h40, 32'h0);
    rd(8'h28, 32'h2);
    wr(8'h00, 32'h20);
    lvl[6:5] <= 2'b11;
    repeat (8) @(posedge mclk);
    #1 chk("pend", pend[6:5], 2'b11);
    chk("gated", gated[6:5], 2'b01);
    wr(8'h10, 32'h20);
    repeat (2) @(posedge mclk);
    #1 chk("pg", {pend[5], gated[5]}, 2'b10);
    stop_test;
  end
endmodule
